// ### shared/power_ctl_pkg.sv
// Shared constants for the watchdog and power-save sequencer
package power_ctl_pkg;
   // Clock and delays
   localparam int CLK_PERIOD_NS = 10;
   localparam int POR_DELAY_NS = 10000;
   localparam int POR_DELAY_CYCLES = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POWERUP_TIMER_BASE_NS = 4000000;
   localparam int POWERUP_TIMER_BASE_CYCLES = POWERUP_TIMER_BASE_NS / CLK_PERIOD_NS;
   localparam int DLY_W = 24;
   // Watchdog counter
   localparam int WDT_W = 16;
   localparam logic [WDT_W-1:0] WDT_LIMIT = 16'hFFFF;
   // Configuration word addresses and layout
   localparam logic [23:0] ADDR_OSC_WORD = 24'hF80000;
   localparam logic [23:0] ADDR_WDT_WORD = 24'hF80002;
   localparam logic [23:0] ADDR_BOR_WORD = 24'hF80004;
   localparam logic [23:0] ADDR_SEG_WORD = 24'hF8000A;
   localparam logic [23:0] CFG_ERASED = 24'hFFFFFF;
   localparam logic [7:0] CFG_UPPER = 8'hFF;
   localparam int CFG_DATA_W = 16;
   localparam int WDT_FUSE_EN_BIT = 15;
   localparam int OSC_FAM_LSB = 8;
   localparam int OSC_MODE_LSB = 0;
   localparam int CLK_SWITCH_BIT = 15;
   localparam int POWERUP_TIMER_SEL_LSB = 0;
   localparam int FAILMON_BIT = 14;
   // Oscillator family codes
   localparam logic [1:0] FAM_LOW_POWER_RC_CLOCK = 2'h0;
   localparam logic [1:0] FAM_FRC = 2'h1;
   localparam logic [1:0] FAM_LP = 2'h2;
   localparam logic [1:0] FAM_PRIMARY = 2'h3;
   // Primary mode codes that need no start-up timer, and the PLL select bit
   localparam logic [3:0] MODE_EXT_CLK = 4'hC;
   localparam logic [3:0] MODE_EXT_RC = 4'h9;
   localparam int MODE_PLL_BIT = 2;
   // Reset control and status register bits
   localparam int RCS_POR = 0;
   localparam int RCS_BOR = 1;
   localparam int RCS_IDLE = 2;
   localparam int RCS_SLEEP = 3;
   localparam int RCS_WDT_TIMEOUT_FLAG = 4;
   localparam int RCS_WDT_SOFT_ENABLE = 5;
   localparam int RCS_SWR = 6;
   localparam int RCS_EXTR = 7;
   localparam logic [15:0] RCS_POR_VALUE = 16'h0003;
   localparam logic [15:0] RCS_IMPL_MASK = 16'h00FF;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_IDLE = 3'b001,
      ST_SLEEP = 3'b010,
      ST_POR_DLY = 3'b011,
      ST_OST = 3'b100,
      ST_LOCK = 3'b101,
      ST_POWERUP_TIMER = 3'b110,
      ST_STALL = 3'b111
   } seq_state_t;
endpackage

// ### src/watchdog_sleep_idle_control.sv
// Watchdog enable, Sleep and Idle sequencer, wake delays and status flags
// Summary of operation
// - Watchdog runs whenever the programmed fuse enable bit is one.
// - An erased configuration array reads all ones, so the watchdog starts enabled.
// - Enabled watchdog counts to overflow; overflow outside Sleep and Idle forces a device reset.
// - Watchdog clear instruction zeroes the count; software must issue it in time.
// - With the fuse bit zero, software enable bit 5 of status register gates the watchdog.
// - Watchdog overflow in Sleep wakes the core and sets sleep and time-out flags.
// - Power-save instruction enters Sleep or Idle as the instruction selects.
// - Sleep gates CPU and peripheral clocks and stops the on-chip oscillator.
// - Sleep idles the failure monitor; RC clock runs for watchdog; brown-out keeps working.
// - Sleep ends on enabled interrupt, any reset, or watchdog time-out.
// - Wake restarts the prior clock; with switching on, current select field chooses it.
// - After power-on or brown-out, oscillator comes from family and mode fuses.
// - Crystal wake waits for start-up timer, PLL lock when the PLL is selected, and all timer delays.
// - Wake to external clock or RC sources applies only the power-on delay.
// - Low-power crystal kept running through Sleep applies only the power-on delay.
// - Clock still dead after delays: failure trap and fast RC, or stall.
// - Interrupt wake from Sleep branches to the handler and sets the sleep flag.
// - Every reset wakes from Sleep; non power-on resets set sleep flag, power-on clears.
// - Idle stops only the CPU clock; peripherals and clock source keep running.
// - Idle wake restores CPU clock at once, resuming next instruction or handler.
// - Idle flag set by interrupt wake and non power-on resets; watchdog wake adds time-out.
// - Configuration words are 24 bits, low 16 used, readable by table reads.
`timescale 1ns/1ns
module watchdog_sleep_idle_control #(
   parameter int POWERUP_TIMER_BASE = power_ctl_pkg::POWERUP_TIMER_BASE_CYCLES
) (
   input wire logic core_clk,
   input wire logic resetn,
   // Non-volatile configuration array, as programmed
   input wire logic nv_erased,
   input wire logic [23:0] nv_osc_word,
   input wire logic [23:0] nv_wdt_word,
   input wire logic [23:0] nv_bor_word,
   input wire logic [23:0] nv_seg_word,
   // Table read port
   input wire logic tbl_rd,
   input wire logic [23:0] tbl_addr,
   output logic [23:0] tbl_rdata,
   output logic tbl_valid,
   // Status register port
   input wire logic rcs_wr,
   input wire logic [15:0] rcs_wdata,
   output logic [15:0] reset_control_status,
   // Instructions from the core
   input wire logic power_save_instr,
   input wire logic power_save_idle,
   input wire logic watchdog_clear_instr,
   input wire logic soft_reset,
   // Wake and reset sources
   input wire logic irq_wake,
   input wire logic brownout_reset,
   input wire logic external_clear_pin,
   input wire logic low_power_rc_clock_tick,
   // Oscillator side
   input wire logic [1:0] cur_osc_sel,
   input wire logic lp_osc_keep,
   input wire logic osc_startup_timer_done,
   input wire logic pll_lock,
   input wire logic osc_clock_running,
   // Outputs to the clock tree and core
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic osc_enable,
   output logic [1:0] sys_clk_sel,
   output logic low_power_rc_clock_en,
   output logic clock_failure_monitor_en,
   output logic fast_rc_forced,
   output logic clk_fail_trap,
   output logic device_reset_req,
   output logic wake_to_handler,
   output logic wake_resume
);
   import power_ctl_pkg::*;

   logic rst_meta;
   logic rst_n;
   logic cfg_loaded;
   logic [23:0] osc_word;
   logic [23:0] wdt_word;
   logic [23:0] bor_word;
   logic [23:0] seg_word;
   logic [WDT_W-1:0] wdt_count;
   logic wdt_on;
   logic wdt_overflow;
   seq_state_t state;
   seq_state_t next_state;
   logic [DLY_W-1:0] dly_count;
   logic [DLY_W-1:0] next_dly;
   logic [1:0] src;
   logic from_fuses;
   logic lp_kept;
   logic src_fast;
   logic src_pll;
   logic [DLY_W-1:0] powerup_timer_cycles;
   logic sleeping;
   logic idling;
   logic sync_reset;
   logic wake_event;
   logic [1:0] fam_fuse;
   logic [3:0] mode_fuse;
   logic [1:0] powerup_timer_sel;

   // Reset release through two flops
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // Fuse capture after release; the array is treated as static once loaded
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_loaded <= 1'b0;
         osc_word <= CFG_ERASED;
         wdt_word <= CFG_ERASED;
         bor_word <= CFG_ERASED;
         seg_word <= CFG_ERASED;
      end else if (!cfg_loaded) begin
         cfg_loaded <= 1'b1;
         osc_word <= nv_erased ? CFG_ERASED : {CFG_UPPER, nv_osc_word[CFG_DATA_W-1:0]};
         wdt_word <= nv_erased ? CFG_ERASED : {CFG_UPPER, nv_wdt_word[CFG_DATA_W-1:0]};
         bor_word <= nv_erased ? CFG_ERASED : {CFG_UPPER, nv_bor_word[CFG_DATA_W-1:0]};
         seg_word <= nv_erased ? CFG_ERASED : {CFG_UPPER, nv_seg_word[CFG_DATA_W-1:0]};
      end
   end

   // Table reads answer one cycle later; unmapped addresses read zero
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tbl_rdata <= 24'h000000;
         tbl_valid <= 1'b0;
      end else begin
         tbl_valid <= tbl_rd;
         if (tbl_rd) begin
            case (tbl_addr)
               ADDR_OSC_WORD: tbl_rdata <= osc_word;
               ADDR_WDT_WORD: tbl_rdata <= wdt_word;
               ADDR_BOR_WORD: tbl_rdata <= bor_word;
               ADDR_SEG_WORD: tbl_rdata <= seg_word;
               default: tbl_rdata <= 24'h000000;
            endcase
         end
      end
   end

   assign fam_fuse = osc_word[OSC_FAM_LSB +: 2];
   assign mode_fuse = osc_word[OSC_MODE_LSB +: 4];
   assign powerup_timer_sel = bor_word[POWERUP_TIMER_SEL_LSB +: 2];
   assign sleeping = (state == ST_SLEEP);
   assign idling = (state == ST_IDLE);
   assign sync_reset = brownout_reset | external_clear_pin | soft_reset | wdt_overflow & !sleeping & !idling;

   // Watchdog: the fuse wins; software bit only matters when the fuse is off
   assign wdt_on = wdt_word[WDT_FUSE_EN_BIT] | reset_control_status[RCS_WDT_SOFT_ENABLE];
   assign wdt_overflow = wdt_on && low_power_rc_clock_tick && (wdt_count == WDT_LIMIT);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wdt_count <= '0;
      end else if (watchdog_clear_instr || sync_reset || wdt_overflow || !wdt_on) begin
         wdt_count <= '0;
      end else if (low_power_rc_clock_tick) begin
         wdt_count <= wdt_count + 1'b1;
      end
   end

   // Device reset request: time-out outside low power, or a pin, software or brown-out reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         device_reset_req <= 1'b0;
      end else begin
         device_reset_req <= sync_reset;
      end
   end

   // Status flags; hardware sets are applied after the software write so a set wins
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reset_control_status <= RCS_POR_VALUE;
      end else begin
         logic [15:0] v;
         v = reset_control_status;
         if (rcs_wr) begin
            v = rcs_wdata & RCS_IMPL_MASK;
         end
         if (brownout_reset) begin
            v[RCS_BOR] = 1'b1;
         end
         if (external_clear_pin) begin
            v[RCS_EXTR] = 1'b1;
            v[RCS_SWR] = 1'b0;
            v[RCS_WDT_TIMEOUT_FLAG] = 1'b0;
         end
         if (soft_reset) begin
            v[RCS_SWR] = 1'b1;
            v[RCS_EXTR] = 1'b0;
            v[RCS_WDT_TIMEOUT_FLAG] = 1'b0;
         end
         if (wdt_overflow && !sleeping && !idling) begin
            v[RCS_WDT_TIMEOUT_FLAG] = 1'b1;
            v[RCS_SWR] = 1'b0;
            v[RCS_EXTR] = 1'b0;
         end
         if (sleeping && (sync_reset || wdt_overflow || irq_wake)) begin
            v[RCS_SLEEP] = 1'b1;
         end
         if (idling && (sync_reset || wdt_overflow || irq_wake)) begin
            v[RCS_IDLE] = 1'b1;
         end
         if ((sleeping || idling) && wdt_overflow) begin
            v[RCS_WDT_TIMEOUT_FLAG] = 1'b1;
         end
         reset_control_status <= v;
      end
   end

   // Clock source: fuses after power-on or brown-out or with clock switching off, else the running selection
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         from_fuses <= 1'b1;
      end else if (brownout_reset) begin
         from_fuses <= 1'b1;
      end else if (state == ST_RUN) begin
         from_fuses <= 1'b0;
      end
   end

   always_comb begin
      if (from_fuses || !osc_word[CLK_SWITCH_BIT]) begin
         src = fam_fuse;
      end else begin
         src = cur_osc_sel;
      end
   end

   assign src_pll = (src == FAM_PRIMARY) && mode_fuse[MODE_PLL_BIT];
   assign src_fast = (src == FAM_LOW_POWER_RC_CLOCK) || (src == FAM_FRC) ||
      (src == FAM_PRIMARY && (mode_fuse == MODE_EXT_CLK || mode_fuse == MODE_EXT_RC));

   // Whether the low-power crystal stayed up through the last Sleep
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lp_kept <= 1'b0;
      end else if (power_save_instr && !power_save_idle) begin
         lp_kept <= lp_osc_keep && (src == FAM_LP);
      end else if (brownout_reset) begin
         lp_kept <= 1'b0;
      end
   end

   always_comb begin
      case (powerup_timer_sel)
         2'h0: powerup_timer_cycles = '0;
         2'h1: powerup_timer_cycles = DLY_W'(POWERUP_TIMER_BASE);
         2'h2: powerup_timer_cycles = DLY_W'(POWERUP_TIMER_BASE * 4);
         default: powerup_timer_cycles = DLY_W'(POWERUP_TIMER_BASE * 16);
      endcase
   end

   assign wake_event = irq_wake | wdt_overflow | sync_reset;

   // Sequencer
   always_comb begin
      next_state = state;
      next_dly = dly_count;
      case (state)
         ST_RUN: begin
            if (power_save_instr) begin
               next_state = power_save_idle ? ST_IDLE : ST_SLEEP;
            end
         end
         ST_IDLE: begin
            if (wake_event) begin
               next_state = ST_RUN;
            end
         end
         ST_SLEEP: begin
            if (wake_event) begin
               next_state = ST_POR_DLY;
               next_dly = DLY_W'(POR_DELAY_CYCLES - 1);
            end
         end
         ST_POR_DLY: begin
            if (dly_count != '0) begin
               next_dly = dly_count - 1'b1;
            end else if (src_fast || lp_kept) begin
               next_state = ST_RUN;
            end else begin
               next_state = ST_OST;
            end
         end
         ST_OST: begin
            if (osc_startup_timer_done) begin
               next_state = src_pll ? ST_LOCK : ST_POWERUP_TIMER;
               next_dly = powerup_timer_cycles;
            end
         end
         ST_LOCK: begin
            if (pll_lock) begin
               next_state = ST_POWERUP_TIMER;
            end
         end
         ST_POWERUP_TIMER: begin
            if (dly_count != '0) begin
               next_dly = dly_count - 1'b1;
            end else if (osc_clock_running) begin
               next_state = ST_RUN;
            end else if (osc_word[FAILMON_BIT]) begin
               next_state = ST_RUN;
            end else begin
               next_state = ST_STALL;
            end
         end
         ST_STALL: begin
            if (osc_clock_running) begin
               next_state = ST_RUN;
            end
         end
         default: next_state = ST_RUN;
      endcase
      // Override here so the clock enables drop on the same edge as the reset request
      if (sync_reset && state != ST_SLEEP) begin
         next_state = ST_POR_DLY;
         next_dly = DLY_W'(POR_DELAY_CYCLES - 1);
      end
   end

   // Start-up after reset goes through the same delay path as a Sleep wake
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_POR_DLY;
         dly_count <= DLY_W'(POR_DELAY_CYCLES - 1);
      end else begin
         state <= next_state;
         dly_count <= next_dly;
      end
   end

   // Failure trap and fast RC takeover when the crystal never came up
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_fail_trap <= 1'b0;
         fast_rc_forced <= 1'b0;
      end else begin
         clk_fail_trap <= (state == ST_POWERUP_TIMER) && (dly_count == '0) && !osc_clock_running &&
            osc_word[FAILMON_BIT];
         if (state == ST_POWERUP_TIMER && dly_count == '0 && !osc_clock_running && osc_word[FAILMON_BIT]) begin
            fast_rc_forced <= 1'b1;
         end else if (power_save_instr || brownout_reset) begin
            fast_rc_forced <= 1'b0;
         end
      end
   end

   // Wake reporting to the core
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_to_handler <= 1'b0;
         wake_resume <= 1'b0;
      end else begin
         wake_to_handler <= (sleeping || idling) && irq_wake && !sync_reset;
         wake_resume <= (sleeping || idling) && wdt_overflow && !irq_wake && !sync_reset;
      end
   end

   // Clock gating outputs, registered to keep them glitch free
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_clk_en <= 1'b0;
         periph_clk_en <= 1'b0;
         osc_enable <= 1'b1;
         sys_clk_sel <= FAM_FRC;
         low_power_rc_clock_en <= 1'b1;
         clock_failure_monitor_en <= 1'b0;
      end else begin
         cpu_clk_en <= (next_state == ST_RUN);
         periph_clk_en <= (next_state == ST_RUN) || (next_state == ST_IDLE);
         osc_enable <= (next_state != ST_SLEEP) || lp_kept;
         sys_clk_sel <= fast_rc_forced ? FAM_FRC : src;
         low_power_rc_clock_en <= wdt_on || (src == FAM_LOW_POWER_RC_CLOCK && next_state != ST_SLEEP) ||
            (osc_word[FAILMON_BIT] && next_state != ST_SLEEP);
         clock_failure_monitor_en <= osc_word[FAILMON_BIT] &&
            (next_state == ST_RUN || next_state == ST_IDLE);
      end
   end
endmodule

// ### verif/power_ctl_checker.sv
// Port-level assertions for the watchdog and power-save sequencer
`timescale 1ns/1ns
module power_ctl_checker (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic tbl_rd,
   input wire logic [23:0] tbl_rdata,
   input wire logic tbl_valid,
   input wire logic [15:0] reset_control_status,
   input wire logic power_save_instr,
   input wire logic power_save_idle,
   input wire logic soft_reset,
   input wire logic irq_wake,
   input wire logic brownout_reset,
   input wire logic external_clear_pin,
   input wire logic cpu_clk_en,
   input wire logic periph_clk_en,
   input wire logic osc_enable,
   input wire logic clock_failure_monitor_en,
   input wire logic device_reset_req,
   input wire logic wake_to_handler
);
   import power_ctl_pkg::*;
   wire logic any_rst = brownout_reset | external_clear_pin | soft_reset;
   wire logic in_idle = !cpu_clk_en && periph_clk_en;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   AST_TBL_VALID: assert property (tbl_rd |=> tbl_valid) else $error("table read not answered");
   AST_TBL_UPPER: assert property (tbl_valid && tbl_rdata != 24'h0 |-> tbl_rdata[23:16] == CFG_UPPER)
      else $error("upper config bits not ones");
   AST_SLEEP_CLKS: assert property (power_save_instr && !power_save_idle && cpu_clk_en
      |=> !cpu_clk_en && !periph_clk_en) else $error("sleep left clocks on");
   AST_IDLE_CLKS: assert property (power_save_instr && power_save_idle && cpu_clk_en
      |=> !cpu_clk_en && periph_clk_en && osc_enable) else $error("idle clock gating wrong");
   AST_IDLE_WAKE: assert property (in_idle && irq_wake && !any_rst
      |-> ##[1:2] (cpu_clk_en && wake_to_handler)) else $error("idle wake not immediate");
   AST_IDLE_FLAG: assert property (in_idle && irq_wake && !any_rst
      |-> ##[1:3] reset_control_status[RCS_IDLE]) else $error("idle flag not set");
   AST_SLEEP_MON: assert property (!periph_clk_en && !osc_enable |-> !clock_failure_monitor_en)
      else $error("monitor active in sleep");
   AST_RESET_REQ: assert property (any_rst && cpu_clk_en |=> device_reset_req)
      else $error("reset request missing");
   AST_RESET_HOLD: assert property (device_reset_req |=> !cpu_clk_en [*8])
      else $error("cpu clock back too soon");
   AST_RSV_ZERO: assert property (reset_control_status[15:8] == 8'h00)
      else $error("reserved status bits set");
   COV_IDLE: cover property (in_idle ##1 wake_to_handler);
   COV_SLEEP: cover property (power_save_instr && !power_save_idle && cpu_clk_en);
   COV_RESET: cover property (device_reset_req);
endmodule
bind watchdog_sleep_idle_control power_ctl_checker i_chk (.core_clk(core_clk), .resetn(resetn),
   .tbl_rd(tbl_rd), .tbl_rdata(tbl_rdata), .tbl_valid(tbl_valid),
   .reset_control_status(reset_control_status), .power_save_instr(power_save_instr),
   .power_save_idle(power_save_idle), .soft_reset(soft_reset), .irq_wake(irq_wake),
   .brownout_reset(brownout_reset), .external_clear_pin(external_clear_pin), .cpu_clk_en(cpu_clk_en),
   .periph_clk_en(periph_clk_en), .osc_enable(osc_enable), .clock_failure_monitor_en(clock_failure_monitor_en),
   .device_reset_req(device_reset_req), .wake_to_handler(wake_to_handler));

// ### verif/watchdog_sleep_idle_control_bench.sv
// Self-checking bench for the watchdog and power-save sequencer
`timescale 1ns/1ns
module watchdog_sleep_idle_control_bench;
   import power_ctl_pkg::*;
   logic core_clk, resetn, nv_erased, tbl_rd, tbl_valid, rcs_wr, power_save_instr, power_save_idle;
   logic watchdog_clear_instr, soft_reset, irq_wake, brownout_reset, external_clear_pin, low_power_rc_clock_tick;
   logic lp_osc_keep, osc_startup_timer_done, pll_lock, osc_clock_running, cpu_clk_en, periph_clk_en;
   logic osc_enable, low_power_rc_clock_en, clock_failure_monitor_en, fast_rc_forced, clk_fail_trap;
   logic device_reset_req, wake_to_handler, wake_resume;
   logic [1:0] cur_osc_sel, sys_clk_sel;
   logic [15:0] rcs_wdata, reset_control_status;
   logic [23:0] tbl_addr, tbl_rdata, nv_osc_word, nv_wdt_word, nv_bor_word, nv_seg_word;
   int n_errors, checks, n_handler, n_reset, waited;
   // Short power-up timer base keeps crystal paths affordable in simulation
   watchdog_sleep_idle_control #(.POWERUP_TIMER_BASE(20)) i_dut (.core_clk, .resetn, .nv_erased, .nv_osc_word,
      .nv_wdt_word, .nv_bor_word, .nv_seg_word, .tbl_rd, .tbl_addr, .tbl_rdata, .tbl_valid, .rcs_wr,
      .rcs_wdata, .reset_control_status, .power_save_instr, .power_save_idle, .watchdog_clear_instr,
      .soft_reset, .irq_wake, .brownout_reset, .external_clear_pin, .low_power_rc_clock_tick, .cur_osc_sel, .lp_osc_keep,
      .osc_startup_timer_done, .pll_lock, .osc_clock_running, .cpu_clk_en, .periph_clk_en, .osc_enable,
      .sys_clk_sel, .low_power_rc_clock_en, .clock_failure_monitor_en, .fast_rc_forced, .clk_fail_trap,
      .device_reset_req, .wake_to_handler, .wake_resume);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (wake_to_handler === 1'b1) n_handler++;
      if (device_reset_req === 1'b1) n_reset++;
   end
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // Bounded: a wake that never completes ends the run
   task automatic wait_run();
      for (waited = 0; waited < 3000 && cpu_clk_en !== 1'b1; waited++) step(1);
      if (cpu_clk_en !== 1'b1) begin
         check("cpu_clk_en", 24'h1, {23'h0, cpu_clk_en});
         stop_test();
      end
   endtask
   task automatic write_rcs(input logic [15:0] v);
      rcs_wdata = v;
      rcs_wr = 1'b1;
      step(1);
      rcs_wr = 1'b0;
   endtask
   task automatic check_rcs(input logic [15:0] v);
      check("status", {8'h00, v}, {8'h00, reset_control_status});
   endtask
   task automatic test_por();
      wait_run();
      check_rcs(RCS_POR_VALUE);
      check("wake delay", 24'h1, {23'h0, waited >= POR_DELAY_CYCLES});
      check("clk sel", {22'h0, FAM_FRC}, {22'h0, sys_clk_sel});
      $display("test por done");
   endtask
   task automatic test_table();
      logic [23:0] a[5] = '{ADDR_OSC_WORD, ADDR_WDT_WORD, ADDR_BOR_WORD, ADDR_SEG_WORD, 24'hF80006};
      logic [23:0] e[5];
      e = '{{CFG_UPPER, nv_osc_word[15:0]}, {CFG_UPPER, nv_wdt_word[15:0]}, {CFG_UPPER, nv_bor_word[15:0]},
         {CFG_UPPER, nv_seg_word[15:0]}, 24'h000000};
      for (int i = 0; i < 5; i++) begin
         tbl_addr = a[i];
         tbl_rd = 1'b1;
         step(1);
         tbl_rd = 1'b0;
         check("tbl_valid", 24'h1, {23'h0, tbl_valid});
         check("tbl_rdata", e[i], tbl_rdata);
         step(1);
      end
      $display("test table done");
   endtask
   task automatic test_status();
      write_rcs(16'hFF20);
      check_rcs(16'h0020);
      step(5);
      check_rcs(16'h0020);
      write_rcs(16'h0000);
      $display("test status done");
   endtask
   task automatic enter_save(input logic idle);
      power_save_idle = idle;
      power_save_instr = 1'b1;
      step(1);
      power_save_instr = 1'b0;
   endtask
   task automatic test_idle();
      n_handler = 0;
      enter_save(1'b1);
      check("idle clocks", 24'h3, {21'h0, cpu_clk_en, periph_clk_en, osc_enable});
      step(4);
      irq_wake = 1'b1;
      step(1);
      irq_wake = 1'b0;
      step(1);
      check("cpu_clk_en", 24'h1, {23'h0, cpu_clk_en});
      step(2);
      check("handler", 24'h1, n_handler[23:0]);
      check_rcs(16'h0004);
      write_rcs(16'h0000);
      $display("test idle done");
   endtask
   task automatic test_sleep();
      n_handler = 0;
      enter_save(1'b0);
      check("sleep clocks", 24'h1, {20'h0, cpu_clk_en, periph_clk_en, osc_enable, low_power_rc_clock_en});
      check("monitor", 24'h0, {23'h0, clock_failure_monitor_en});
      step(10);
      check("no wake", 24'h0, {23'h0, cpu_clk_en});
      irq_wake = 1'b1;
      step(1);
      irq_wake = 1'b0;
      wait_run();
      step(2);
      check("wake delay", 24'h1, {23'h0, waited >= POR_DELAY_CYCLES - 2});
      check("handler", 24'h1, n_handler[23:0]);
      check_rcs(16'h0008);
      check("clk sel", {22'h0, cur_osc_sel}, {22'h0, sys_clk_sel});
      write_rcs(16'h0000);
      $display("test sleep done");
   endtask
   task automatic test_resets();
      soft_reset = 1'b1;
      step(1);
      soft_reset = 1'b0;
      check("reset req", 24'h1, {23'h0, device_reset_req});
      check("clock off", 24'h0, {23'h0, cpu_clk_en});
      step(2);
      wait_run();
      check_rcs(16'h0040);
      write_rcs(16'h0000);
      enter_save(1'b1);
      external_clear_pin = 1'b1;
      step(1);
      external_clear_pin = 1'b0;
      step(2);
      wait_run();
      check_rcs(16'h0084);
      write_rcs(16'h0000);
      $display("test resets done");
   endtask
   task automatic test_wdt();
      low_power_rc_clock_tick = 1'b1;
      step(100);
      low_power_rc_clock_tick = 1'b0;
      watchdog_clear_instr = 1'b1;
      step(1);
      watchdog_clear_instr = 1'b0;
      n_reset = 0;
      low_power_rc_clock_tick = 1'b1;
      step(65535);
      low_power_rc_clock_tick = 1'b0;
      step(2);
      check("early reset", 24'h0, n_reset[23:0]);
      low_power_rc_clock_tick = 1'b1;
      step(1);
      low_power_rc_clock_tick = 1'b0;
      step(3);
      check("wdt reset", 24'h1, n_reset[23:0]);
      wait_run();
      check_rcs(16'h0010);
      $display("test watchdog done");
   endtask
   // Dead crystal behind the PLL with the failure monitor fused on; fuses reload only on power-on
   task automatic test_fail();
      resetn = 1'b0;
      nv_osc_word = 24'h004304;
      osc_clock_running = 1'b0;
      step(2);
      check_rcs(RCS_POR_VALUE);
      resetn = 1'b1;
      wait_run();
      check("crystal delay", 24'h1, {23'h0, waited >= POR_DELAY_CYCLES});
      check("trap", 24'h1, {23'h0, clk_fail_trap});
      check("fast rc", 24'h1, {23'h0, fast_rc_forced});
      step(1);
      check("trap clk sel", {22'h0, FAM_FRC}, {22'h0, sys_clk_sel});
      check("monitor on", 24'h1, {23'h0, clock_failure_monitor_en});
      $display("test fail done");
   endtask
   initial begin
      {resetn, tbl_rd, rcs_wr, power_save_instr, power_save_idle, watchdog_clear_instr} = '0;
      {soft_reset, irq_wake, brownout_reset, external_clear_pin, low_power_rc_clock_tick, lp_osc_keep, nv_erased} = '0;
      {osc_startup_timer_done, pll_lock, osc_clock_running} = 3'b111;
      cur_osc_sel = FAM_FRC;
      nv_osc_word = 24'h000100;
      nv_wdt_word = 24'h008000;
      nv_bor_word = 24'h000000;
      nv_seg_word = 24'h001234;
      tbl_addr = 24'h0;
      rcs_wdata = 16'h0;
      step(20);
      check_rcs(RCS_POR_VALUE);
      resetn = 1'b1;
      test_por();
      test_table();
      test_status();
      test_idle();
      test_sleep();
      test_resets();
      test_wdt();
      test_fail();
      stop_test();
   end
endmodule
